/* rtl/fuse_config_latch.sv */
// fuse store, latched configuration, signature and calibration readout
`timescale 1ns/10ps
`default_nettype none
module fuse_config_latch
   import fuse_config_pkg::*;
#(
   parameter logic [7:0] SIG_BYTE_0 = 8'hA5, // arbitrary
   parameter logic [7:0] SIG_BYTE_1 = 8'h5A, // arbitrary
   parameter logic [7:0] SIG_BYTE_2 = 8'h3C, // arbitrary
   parameter logic [7:0] CAL_BYTE = 8'h80,
   parameter int PROG_ADDR_W = 13,
   parameter int EE_ADDR_W = 9
) (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // programming mode pin and interface select
   input wire logic prog_mode_pin,
   input wire logic serial_if,
   // store writes
   input wire logic wr_stb,
   input wire logic [1:0] wr_sel,
   input wire logic [7:0] wr_data,
   input wire logic chip_erase_stb,
   // reads
   input wire logic rd_stb,
   input wire logic [1:0] rd_space,
   input wire logic [1:0] rd_addr,
   output logic [7:0] rd_data,
   output logic rd_valid,
   // address split
   input wire logic [PROG_ADDR_W-1:0] prog_addr,
   input wire logic [EE_ADDR_W-1:0] ee_addr,
   output logic [5:0] flash_word_in_page,
   output logic [6:0] flash_page_index,
   output logic [1:0] eeprom_byte_in_page,
   output logic [6:0] eeprom_page_index,
   // latched configuration
   output logic [2:0] brownout_level,
   output logic ext_reset_disable,
   output logic onchip_debug_enable,
   output logic boundary_scan_enable,
   output logic serial_prog_enable,
   output logic watchdog_always_on,
   output logic eeprom_preserve_on_erase,
   output logic [1:0] boot_size,
   output logic reset_vector_select,
   output logic clock_div_by_eight,
   output logic [1:0] startup_time,
   output logic [3:0] clock_source,
   output logic keep_clocks_in_sleep,
   output logic clock_out_pin,
   output logic clock_out_oe,
   output logic memory_lock_first,
   output logic [7:0] osc_calibration_reg,
   output logic prog_mode
);
   initial begin
      if (PROG_ADDR_W != FLASH_PAGE_MSB + 1 || EE_ADDR_W != EE_PAGE_MSB + 1) begin
         $error("address widths do not match the page geometry");
      end
   end

   ////////////////////////////////////////////////////////////////////////
   logic rst_a_r, rst_q_r;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_a_r <= 1'b0;
         rst_q_r <= 1'b0;
      end else begin
         rst_a_r <= 1'b1;
         rst_q_r <= rst_a_r;
      end
   end

   // pin sync: change accepted once stages two and three agree
   logic pm_s1_r, pm_s2_r, pm_s3_r, prog_mode_r, prog_mode_nxt;
   always_ff @(posedge clk or negedge rst_q_r) begin
      if (!rst_q_r) begin
         pm_s1_r <= 1'b0;
         pm_s2_r <= 1'b0;
         pm_s3_r <= 1'b0;
         prog_mode_r <= 1'b0;
      end else begin
         pm_s1_r <= prog_mode_pin;
         pm_s2_r <= pm_s1_r;
         pm_s3_r <= pm_s2_r;
         prog_mode_r <= prog_mode_nxt;
      end
   end
   assign prog_mode_nxt = (pm_s2_r == pm_s3_r) ? pm_s2_r : prog_mode_r;
   assign prog_mode = prog_mode_r;
   wire prog_entry = prog_mode_nxt && !prog_mode_r;

   ////////////////////////////////////////////////////////////////////////
   // nonvolatile store, modelled as flops loaded with the shipped values
   logic [7:0] ext_r, high_r, low_r, lock_r;
   wire locked = !lock_r[LOCK_FIRST_BIT];
   wire fuse_wr_ok = wr_stb && prog_mode_r && !locked;
   wire [7:0] high_wr = serial_if ? {wr_data[7:SERIAL_BIT+1], high_r[SERIAL_BIT],
      wr_data[SERIAL_BIT-1:0]} : wr_data;
   always_ff @(posedge clk or negedge rst_q_r) begin
      if (!rst_q_r) begin
         ext_r <= EXT_DEFAULT;
         high_r <= HIGH_DEFAULT;
         low_r <= LOW_DEFAULT;
         lock_r <= LOCK_ERASED;
      end else begin
         if (fuse_wr_ok && wr_sel == SEL_EXT) begin
            ext_r <= wr_data | EXT_UNUSED_MASK;
         end
         if (fuse_wr_ok && wr_sel == SEL_HIGH) begin
            high_r <= high_wr;
         end
         if (fuse_wr_ok && wr_sel == SEL_LOW) begin
            low_r <= wr_data;
         end
         // erase touches only the lock byte, fuses stay
         if (chip_erase_stb && prog_mode_r) begin
            lock_r <= LOCK_ERASED;
         end else if (wr_stb && prog_mode_r && wr_sel == SEL_LOCK) begin
            lock_r <= lock_r & wr_data; // lock bits only go to programmed
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // active copy: taken once after reset and at each programming entry
   logic [7:0] ext_act_r, high_act_r, low_act_r;
   logic powered_r;
   wire latch_now = (!powered_r && !prog_mode_nxt) || prog_entry;
   always_ff @(posedge clk or negedge rst_q_r) begin
      if (!rst_q_r) begin
         ext_act_r <= EXT_DEFAULT;
         high_act_r <= HIGH_DEFAULT;
         low_act_r <= LOW_DEFAULT;
         powered_r <= 1'b0;
      end else begin
         powered_r <= 1'b1;
         if (latch_now) begin
            ext_act_r <= ext_r;
            high_act_r <= high_r;
            low_act_r <= low_r;
         end
      end
   end

   // zero means programmed, so most enables are the inverted bit
   assign brownout_level = ext_act_r[BOD_MSB:BOD_LSB];
   assign ext_reset_disable = !ext_act_r[EXT_RST_DIS_BIT];
   assign onchip_debug_enable = !high_act_r[OCD_BIT];
   assign boundary_scan_enable = !high_act_r[SCAN_BIT];
   assign serial_prog_enable = !high_act_r[SERIAL_BIT];
   assign watchdog_always_on = !high_act_r[WDT_BIT];
   // a freshly programmed preserve bit needs no latch
   assign eeprom_preserve_on_erase = !(high_act_r[PRESERVE_BIT] && high_r[PRESERVE_BIT]);
   assign boot_size = {high_act_r[BOOT_HI_BIT], high_act_r[BOOT_LO_BIT]};
   assign reset_vector_select = high_act_r[RSTVEC_BIT];
   assign clock_div_by_eight = !low_act_r[DIV8_BIT];
   assign startup_time = {low_act_r[SUT_HI_BIT], low_act_r[SUT_LO_BIT]};
   assign clock_source = low_act_r[CKSRC_MSB:0];
   assign keep_clocks_in_sleep = onchip_debug_enable;
   assign memory_lock_first = locked;

   // enable flips on the falling edge so the gated clock never chops a pulse
   logic clock_output_enable_en_r;
   always_ff @(negedge clk or negedge rst_q_r) begin
      if (!rst_q_r) begin
         clock_output_enable_en_r <= 1'b0;
      end else begin
         clock_output_enable_en_r <= !low_act_r[CLOCK_OUTPUT_ENABLE_BIT];
      end
   end
   assign clock_out_pin = clk & clock_output_enable_en_r;
   assign clock_out_oe = clock_output_enable_en_r;

   ////////////////////////////////////////////////////////////////////////
   // calibration copy: held at the factory value for as long as reset lasts
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         osc_calibration_reg <= CAL_BYTE;
      end else if (!rst_q_r) begin
         osc_calibration_reg <= CAL_BYTE;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // reads ignore the lock bits on purpose
   wire [7:0] sig_byte = (rd_addr == SIG_ADDR_0) ? SIG_BYTE_0 :
      (rd_addr == SIG_ADDR_1) ? SIG_BYTE_1 :
      (rd_addr == SIG_ADDR_2) ? SIG_BYTE_2 : 8'h00;
   wire [7:0] fuse_byte = (rd_addr == SEL_EXT) ? ext_r :
      (rd_addr == SEL_HIGH) ? high_r :
      (rd_addr == SEL_LOW) ? low_r : lock_r;
   wire [7:0] cal_byte = (rd_addr == SIG_ADDR_0) ? CAL_BYTE : 8'h00;
   wire [7:0] rd_mux = (rd_space == SPACE_SIG) ? sig_byte :
      (rd_space == SPACE_FUSE) ? fuse_byte :
      (rd_space == SPACE_CAL) ? cal_byte : 8'h00;
   always_ff @(posedge clk or negedge rst_q_r) begin
      if (!rst_q_r) begin
         rd_data <= 8'h00;
         rd_valid <= 1'b0;
      end else begin
         rd_valid <= rd_stb;
         if (rd_stb) begin
            rd_data <= rd_mux;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk or negedge rst_q_r) begin
      if (!rst_q_r) begin
         flash_word_in_page <= 6'h00;
         flash_page_index <= 7'h00;
         eeprom_byte_in_page <= 2'h0;
         eeprom_page_index <= 7'h00;
      end else begin
         flash_word_in_page <= prog_addr[FLASH_WORD_MSB:0];
         flash_page_index <= prog_addr[FLASH_PAGE_MSB:FLASH_PAGE_LSB];
         eeprom_byte_in_page <= ee_addr[EE_BYTE_MSB:0];
         eeprom_page_index <= ee_addr[EE_PAGE_MSB:EE_PAGE_LSB];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_q_r);

   a_lock_blocks_fuse: assert property (locked && wr_stb |=> $stable(ext_r) && $stable(high_r) && $stable(low_r))
      else $error("fuse changed while locked");
   a_erase_keeps_fuse: assert property (chip_erase_stb |=> $stable(ext_r) && $stable(high_r) && $stable(low_r))
      else $error("chip erase altered a fuse");
   a_serial_keeps_spi: assert property (serial_if && wr_stb && wr_sel == SEL_HIGH |=> $stable(high_r[SERIAL_BIT]))
      else $error("serial interface changed serial enable");
   a_hold_in_prog: assert property (prog_mode_r && prog_mode_nxt |=> $stable(high_act_r) && $stable(low_act_r))
      else $error("active config moved inside programming mode");
   a_latch_on_entry: assert property (prog_entry |=> low_act_r == $past(low_r) && ext_act_r == $past(ext_r))
      else $error("entry did not latch the store");
   a_preserve_at_once: assert property ($fell(high_r[PRESERVE_BIT]) |-> eeprom_preserve_on_erase)
      else $error("preserve fuse not effective at once");
   a_ext_unused_ones: assert property (ext_r[7:4] == 4'hF)
      else $error("unused extended bits not one");
   a_sig_readout: assert property (rd_stb && rd_space == SPACE_SIG && rd_addr == SIG_ADDR_1 |=> rd_valid && rd_data == SIG_BYTE_1)
      else $error("signature byte wrong");
   a_cal_copied: assert property (osc_calibration_reg == CAL_BYTE)
      else $error("calibration register not loaded");
   a_powerup_latch: assert property ($rose(powered_r) && !prog_mode_r |-> high_act_r == high_r)
      else $error("power-up latch missed");

   // read handshake: answer exactly one cycle on, data parked until the next request
   a_rd_valid_next: assert property (rd_stb |=> rd_valid)
      else $error("read not answered next cycle");
   a_rd_valid_pulse: assert property (!rd_stb |=> !rd_valid)
      else $error("read valid without request");
   a_rd_data_holds: assert property (!rd_stb |=> $stable(rd_data))
      else $error("read data moved without request");
   a_sig_byte_zero: assert property (rd_stb && rd_space == SPACE_SIG && rd_addr == SIG_ADDR_0 |=> rd_data == SIG_BYTE_0)
      else $error("signature byte zero wrong");
   a_sig_byte_two: assert property (rd_stb && rd_space == SPACE_SIG && rd_addr == SIG_ADDR_2 |=> rd_data == SIG_BYTE_2)
      else $error("signature byte two wrong");
   a_cal_readout: assert property (rd_stb && rd_space == SPACE_CAL && rd_addr == SIG_ADDR_0 |=> rd_data == CAL_BYTE)
      else $error("calibration byte readout wrong");
   a_fuse_readback: assert property (rd_stb && rd_space == SPACE_FUSE && rd_addr == SEL_HIGH
      |=> rd_data == $past(high_r))
      else $error("high fuse readback wrong");
   a_lock_readback: assert property (rd_stb && rd_space == SPACE_FUSE && rd_addr == SEL_LOCK
      |=> rd_data == $past(lock_r))
      else $error("lock byte readback wrong");

   // store writes
   a_ext_write_lands: assert property (fuse_wr_ok && wr_sel == SEL_EXT
      |=> ext_r == ($past(wr_data) | EXT_UNUSED_MASK))
      else $error("extended write lost");
   a_low_write_lands: assert property (fuse_wr_ok && wr_sel == SEL_LOW |=> low_r == $past(wr_data))
      else $error("low write lost");
   a_high_write_lands: assert property (!serial_if && fuse_wr_ok && wr_sel == SEL_HIGH |=> high_r == $past(wr_data))
      else $error("high write lost");
   a_no_write_outside: assert property (!prog_mode_r |=> $stable(ext_r) && $stable(high_r) && $stable(low_r))
      else $error("fuse written outside programming mode");
   a_lock_only_programs: assert property (!chip_erase_stb |=> (lock_r & ~$past(lock_r)) == 8'h00)
      else $error("lock bit unprogrammed by a write");
   a_erase_clears_lock: assert property (chip_erase_stb && prog_mode_r |=> lock_r == LOCK_ERASED)
      else $error("erase left lock bits set");

   // active copy and the units it feeds
   a_latch_entry_high: assert property (prog_entry |=> high_act_r == $past(high_r))
      else $error("entry did not latch high byte");
   a_hold_outside_latch: assert property (!latch_now
      |=> $stable(ext_act_r) && $stable(high_act_r) && $stable(low_act_r))
      else $error("active config moved between latches");
   a_mode_debounce: assert property (pm_s2_r != pm_s3_r |=> $stable(prog_mode_r))
      else $error("mode moved while pin stages disagree");
   a_preserve_latched: assert property (!high_act_r[PRESERVE_BIT] |-> eeprom_preserve_on_erase)
      else $error("latched preserve fuse ignored");
   a_debug_keeps_clk: assert property (onchip_debug_enable |-> keep_clocks_in_sleep)
      else $error("debug fuse lets clocks stop");
   a_clock_output_enable_follows: assert property (clock_out_oe == !low_act_r[CLOCK_OUTPUT_ENABLE_BIT])
      else $error("clock output enable off its fuse");

   // address split, one cycle of latency
   a_flash_split: assert property (1'b1 |=> flash_word_in_page == $past(prog_addr[FLASH_WORD_MSB:0])
      && flash_page_index == $past(prog_addr[FLASH_PAGE_MSB:FLASH_PAGE_LSB]))
      else $error("flash address split wrong");
   a_ee_split: assert property (1'b1 |=> eeprom_byte_in_page == $past(ee_addr[EE_BYTE_MSB:0])
      && eeprom_page_index == $past(ee_addr[EE_PAGE_MSB:EE_PAGE_LSB]))
      else $error("eeprom address split wrong");
endmodule // fuse_config_latch
`default_nettype wire

/* rtl/fuse_config_pkg.sv */
// constants, field layout and types of the configuration store
package fuse_config_pkg;
   localparam logic [7:0] EXT_DEFAULT = 8'hFF;
   localparam logic [7:0] HIGH_DEFAULT = 8'h99;
   localparam logic [7:0] LOW_DEFAULT = 8'h62;
   localparam logic [7:0] EXT_UNUSED_MASK = 8'hF0;
   localparam logic [7:0] LOCK_ERASED = 8'hFF;
   localparam int EXT_RST_DIS_BIT = 0;
   localparam int BOD_LSB = 1;
   localparam int BOD_MSB = 3;
   localparam int OCD_BIT = 7;
   localparam int SCAN_BIT = 6;
   localparam int SERIAL_BIT = 5;
   localparam int WDT_BIT = 4;
   localparam int PRESERVE_BIT = 3;
   localparam int BOOT_HI_BIT = 2;
   localparam int BOOT_LO_BIT = 1;
   localparam int RSTVEC_BIT = 0;
   localparam int DIV8_BIT = 7;
   localparam int CLOCK_OUTPUT_ENABLE_BIT = 6;
   localparam int SUT_HI_BIT = 5;
   localparam int SUT_LO_BIT = 4;
   localparam int CKSRC_MSB = 3;
   localparam int LOCK_FIRST_BIT = 0;
   localparam logic [1:0] SIG_ADDR_0 = 2'h0;
   localparam logic [1:0] SIG_ADDR_1 = 2'h1;
   localparam logic [1:0] SIG_ADDR_2 = 2'h2;
   localparam int FLASH_WORD_MSB = 5;
   localparam int FLASH_PAGE_LSB = 6;
   localparam int FLASH_PAGE_MSB = 12;
   localparam int EE_BYTE_MSB = 1;
   localparam int EE_PAGE_LSB = 2;
   localparam int EE_PAGE_MSB = 8;
   typedef enum logic [1:0] {SEL_EXT, SEL_HIGH, SEL_LOW, SEL_LOCK} fuse_sel_t;
   typedef enum logic [1:0] {SPACE_SIG, SPACE_FUSE, SPACE_CAL} rd_space_t;
endpackage

/* test/prog_model.sv */
// programmer model: mode pin and store writes
`timescale 1ns/10ps
`default_nettype none
module prog_model (
   // clock
   input wire logic clk,
   // mode pin and store access
   output logic prog_mode_pin,
   output logic serial_if,
   output logic wr_stb,
   output logic [1:0] wr_sel,
   output logic [7:0] wr_data,
   output logic chip_erase_stb
);
   initial begin
      prog_mode_pin = 1'b0;
      serial_if = 1'b0;
      wr_stb = 1'b0;
      wr_sel = 2'h0;
      wr_data = 8'h00;
      chip_erase_stb = 1'b0;
   end
   // caller picks the order; a fuse write after the lock write checks the lock
   task automatic wr(input logic [1:0] s, input logic [7:0] d, input logic ser);
      @(negedge clk);
      wr_sel = s;
      wr_data = d;
      serial_if = ser;
      wr_stb = 1'b1;
      @(negedge clk);
      wr_stb = 1'b0;
      wr_data = ~d;
      serial_if = 1'b0;
   endtask
   task automatic erase();
      @(negedge clk);
      chip_erase_stb = 1'b1;
      @(negedge clk);
      chip_erase_stb = 1'b0;
   endtask
   // pin held 12 cycles, well past the 250 ns minimum
   task automatic mode(input logic v);
      @(negedge clk);
      prog_mode_pin = v;
      repeat (12) @(negedge clk);
   endtask
endmodule // prog_model
`default_nettype wire

/* test/tb_top.sv */
// self-checking bench of the configuration store
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import fuse_config_pkg::*;
   // arbitrary signature and calibration values
   localparam logic [7:0] S0 = 8'h11;
   localparam logic [7:0] S1 = 8'h22;
   localparam logic [7:0] S2 = 8'h33;
   localparam logic [7:0] CAL = 8'h3b;
   logic clk, arst_n, rd_stb, rd_valid;
   logic [1:0] rd_space, rd_addr, wr_sel, boot_size, startup_time, eeprom_byte_in_page;
   logic [12:0] prog_addr;
   logic [8:0] ee_addr;
   logic prog_mode_pin, serial_if, wr_stb, chip_erase_stb, prog_mode, memory_lock_first;
   logic [7:0] wr_data, rd_data, osc_calibration_reg;
   logic [5:0] flash_word_in_page;
   logic [6:0] flash_page_index, eeprom_page_index;
   logic [2:0] brownout_level;
   logic [3:0] clock_source;
   logic ext_reset_disable, onchip_debug_enable, boundary_scan_enable, serial_prog_enable;
   logic watchdog_always_on, eeprom_preserve_on_erase, reset_vector_select, clock_div_by_eight;
   logic keep_clocks_in_sleep, clock_out_pin, clock_out_oe;
   int err_count, compares;
   ////////////////////////////////////////////////////////////////
   fuse_config_latch #(.SIG_BYTE_0(S0), .SIG_BYTE_1(S1), .SIG_BYTE_2(S2), .CAL_BYTE(CAL)) DUT (
      .clk, .arst_n, .prog_mode_pin, .serial_if, .wr_stb, .wr_sel, .wr_data, .chip_erase_stb,
      .rd_stb, .rd_space, .rd_addr, .rd_data, .rd_valid, .prog_addr, .ee_addr,
      .flash_word_in_page, .flash_page_index, .eeprom_byte_in_page, .eeprom_page_index,
      .brownout_level, .ext_reset_disable, .onchip_debug_enable, .boundary_scan_enable,
      .serial_prog_enable, .watchdog_always_on, .eeprom_preserve_on_erase, .boot_size,
      .reset_vector_select, .clock_div_by_eight, .startup_time, .clock_source,
      .keep_clocks_in_sleep, .clock_out_pin, .clock_out_oe, .memory_lock_first,
      .osc_calibration_reg, .prog_mode);
   prog_model pm (.clk, .prog_mode_pin, .serial_if, .wr_stb, .wr_sel, .wr_data, .chip_erase_stb);
   ////////////////////////////////////////////////////////////////
   task automatic results();
      $display("errors %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      compares++;
      if (g !== e) begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // active fuses rebuilt as bytes, active-high flags turned back to fuse sense
   task automatic latched(input logic [7:0] e, input logic [7:0] h, input logic [7:0] l);
      chk({4'hf, brownout_level, ~ext_reset_disable}, e);
      chk({~onchip_debug_enable, ~boundary_scan_enable, ~serial_prog_enable, ~watchdog_always_on,
           ~eeprom_preserve_on_erase, boot_size, reset_vector_select}, h);
      chk({~clock_div_by_eight, ~clock_out_oe, startup_time, clock_source}, l);
      chk({7'h0, keep_clocks_in_sleep}, {7'h0, ~h[7]});
   endtask
   task automatic rd(input logic [1:0] s, input logic [1:0] a, input logic [7:0] e);
      int n;
      @(negedge clk);
      rd_space = s;
      rd_addr = a;
      rd_stb = 1'b1;
      @(negedge clk);
      rd_stb = 1'b0;
      n = 0;
      while (rd_valid !== 1'b1 && n < 4) begin
         @(negedge clk);
         n++;
      end
      if (n == 4) begin
         err_count++;
         results();
      end
      chk(rd_data, e);
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      arst_n = 1'b0;
      rd_stb = 1'b0;
      rd_space = 2'h0;
      rd_addr = 2'h0;
      prog_addr = 13'h0000;
      ee_addr = 9'h000;
      repeat (8) @(negedge clk);
      arst_n = 1'b1;
      repeat (3) @(negedge clk);
      latched(8'hff, 8'h99, 8'h62);
      chk(osc_calibration_reg, CAL);
      rd(2'd0, 2'd0, S0);
      rd(2'd0, 2'd1, S1);
      rd(2'd0, 2'd2, S2);
      rd(2'd0, 2'd3, 8'h00);
      rd(2'd2, 2'd0, CAL);
      rd(2'd1, 2'd1, 8'h99);
      rd(2'd1, 2'd2, 8'h62);
      pm.wr(2'd0, 8'h00, 1'b0);
      rd(2'd1, 2'd0, 8'hff);
      pm.mode(1'b1);
      chk({7'h0, prog_mode}, 8'h01);
      pm.wr(2'd0, 8'h00, 1'b0);
      rd(2'd1, 2'd0, 8'hf0);
      // serial writer tries to unprogram the serial enable
      pm.wr(2'd1, 8'h31, 1'b1);
      rd(2'd1, 2'd1, 8'h11);
      chk({7'h0, eeprom_preserve_on_erase}, 8'h01);
      pm.wr(2'd2, 8'h22, 1'b0);
      pm.wr(2'd3, 8'hfe, 1'b0);
      chk({7'h0, memory_lock_first}, 8'h01);
      pm.wr(2'd0, 8'hff, 1'b0);
      rd(2'd1, 2'd0, 8'hf0);
      pm.erase();
      rd(2'd1, 2'd3, 8'hff);
      rd(2'd1, 2'd1, 8'h11);
      rd(2'd1, 2'd2, 8'h22);
      latched(8'hff, 8'h91, 8'h62);
      pm.mode(1'b0);
      pm.mode(1'b1);
      latched(8'hf0, 8'h11, 8'h22);
      @(posedge clk);
      #2 chk({7'h0, clock_out_pin}, 8'h01);
      @(negedge clk);
      #2 chk({7'h0, clock_out_pin}, 8'h00);
      prog_addr = 13'h1abc;
      ee_addr = 9'h1a7;
      repeat (2) @(negedge clk);
      chk({2'h0, flash_word_in_page}, 8'h3c);
      chk({1'h0, flash_page_index}, 8'h6a);
      chk({6'h0, eeprom_byte_in_page}, 8'h03);
      chk({1'h0, eeprom_page_index}, 8'h69);
      results();
   end
endmodule // tb_top
`default_nettype wire
